// ---- core/eqddc_pkg.sv ----
// eqddc_pkg: constants, types and helpers shared by the equalizer and down converter
// assumes a single device clock domain for all users
package eqddc_pkg;
    localparam int DW        = 12;  // sample width
    localparam int NTAP      = 9;   // taps per coefficient set
    localparam int CTR_TAP   = 4;   // center tap position
    localparam int NOSC      = 4;   // oscillators per down converter
    localparam int FW        = 32;  // frequency word width
    localparam int CTR_SHIFT = 16;  // center tap lsb weight exponent
    localparam int MIX_SHIFT = 11;  // mixer product scaling
    localparam int DEC_SHIFT = 3;   // decimator gain 8
    localparam logic [2:0] WSEL_MAX = 3'h6; // tap weight 2^-16

    // register offsets (byte addresses)
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_FREQ   = 12'h040; // 8 words: a0..a3, b0..b3
    localparam logic [11:0] OFS_COEF   = 12'h100; // 18 words: set a 0..8, set b 0..8

    // control field positions
    localparam int CTRL_MODE   = 0;  // [1:0]
    localparam int CTRL_SHARE  = 2;
    localparam int CTRL_MERGE  = 3;
    localparam int CTRL_WSEL   = 4;  // [6:4]
    localparam int CTRL_SINGLE = 7;
    localparam int CTRL_BYPASS = 8;
    localparam int CTRL_BIND_A = 9;
    localparam int CTRL_BIND_B = 10;
    localparam int CTRL_SRC    = 11;
    localparam int CTRL_FSEL_A = 12; // [13:12]
    localparam int CTRL_FSEL_B = 14; // [15:14]
    localparam logic [31:0] CTRL_RESET = 32'h0000_0500;
    localparam logic [31:0] FREQ_RESET = 32'h0000_0000;
    localparam logic [17:0] COEF_RESET = 18'h0_0000;

    localparam logic [1:0] EQ_MODE_OFF = 2'h0;
    localparam logic [1:0] EQ_MODE_ON  = 2'h2;

    typedef enum logic [3:0] {
        EQ_OFF    = 4'b0001,
        EQ_DUAL   = 4'b0010,
        EQ_SINGLE = 4'b0100,
        EQ_TVAR   = 4'b1000
    } eq_mode_e;

    typedef logic [17:0] coef_t;
    typedef coef_t [NTAP-1:0] coef_set_t;
    typedef logic [NOSC-1:0] [FW-1:0] freq_set_t;

    typedef struct packed {
        logic          valid;
        logic [DW-1:0] i;
        logic [DW-1:0] q;
    } sample_s;

    // convergent rounding by sh bits, then saturation to a signed 12-bit code
    function automatic logic [DW-1:0] round_sat(input logic signed [47:0] v,
                                                 input logic [5:0] sh);
        logic signed [47:0] q;
        logic [47:0]        rem;
        logic [47:0]        half;
        q    = v >>> sh;
        rem  = v & ((48'h1 << sh) - 48'h1);
        half = 48'h1 << (sh - 6'h1);
        if (rem > half || (rem == half && q[0]))
            q = q + 48'sh1;
        if (q > 48'sh7ff)
            return 12'h7ff;
        else if (q < -48'sh800)
            return 12'h800;
        return q[DW-1:0];
    endfunction
endpackage

// ---- core/eq_fir.sv ----
// eq_fir: one 9-tap equalizer channel with programmable coefficient set
// assumes one sample per valid cycle and coefficients that stay still while enabled
`timescale 1ns/1ps
module eq_fir
    import eqddc_pkg::*;
(
    input  wire logic          clk,       // device clock
    input  wire logic          rst_n,     // synchronised reset, active low
    input  wire logic          enable,    // filter on, else pass through
    input  wire logic [2:0]    wsel,      // non-center lsb weight 2^-(10+wsel)
    input  wire coef_set_t     coefs,     // coefficient set in use
    input  wire logic          in_valid,  // input sample strobe
    input  wire logic [DW-1:0] in_data,   // input sample
    output logic               out_valid, // output strobe, one cycle after input
    output logic [DW-1:0]      out_data   // filtered sample
);
    logic [NTAP-2:0] [DW-1:0] hist;
    logic [NTAP-1:0] [DW-1:0] win;
    logic signed [47:0] term [NTAP];
    logic [NTAP-2:0] [DW-1:0] next_hist;
    logic               next_valid;
    logic [DW-1:0]      next_data;
    logic signed [47:0] acc;

    // products aligned to 2^-16, full precision kept until the output
    for (genvar k = 0; k < NTAP; k++) begin : g_tap
        if (k == 0) begin : g_in
            assign win[k] = in_data;
        end else begin : g_hist
            assign win[k] = hist[k-1];
        end
        if (k == CTR_TAP) begin : g_ctr
            assign term[k] = 48'($signed(win[k])) * 48'($signed(coefs[k])); // [RQ3] [RQ20]
        end else begin : g_side
            assign term[k] = (48'($signed(win[k])) * 48'($signed(coefs[k][11:0])))
                             <<< (WSEL_MAX - wsel); // [RQ4]
        end
    end

    // accumulate, round once at the output
    always_comb begin
        acc = 48'sh0;
        for (int k = 0; k < NTAP; k++)
            acc = acc + term[k]; // [RQ15]
        next_hist  = in_valid ? {hist[NTAP-3:0], in_data} : hist;
        next_valid = in_valid;
        next_data  = out_data;
        if (in_valid)
            next_data = enable ? round_sat(acc, 6'(CTR_SHIFT)) : in_data; // [RQ13] [RQ14]
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hist      <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            hist      <= next_hist;
            out_valid <= next_valid;
            out_data  <= next_data;
        end
    end
endmodule

// ---- core/ddc_path.sv ----
// ddc_path: four free-running oscillators, complex mixer and decimate-by-two filter
// assumes a real sample stream and an oscillator index stable per sample
`timescale 1ns/1ps
module ddc_path
    import eqddc_pkg::*;
(
    input  wire logic          clk,      // device clock
    input  wire logic          rst_n,    // synchronised reset, active low
    input  wire freq_set_t     freq,     // frequency words of the four oscillators
    input  wire logic [1:0]    osc_sel,  // active oscillator
    input  wire logic          active,   // path in use
    input  wire logic          in_valid, // input sample strobe
    input  wire logic [DW-1:0] in_data,  // real input sample
    output sample_s            out       // decimated complex output
);
    logic [NOSC-1:0] [FW-1:0] phase;
    logic [NOSC-1:0] [FW-1:0] next_phase;
    logic [1:0] [DW-1:0] mix;
    logic [1:0] [DW-1:0] next_mix;
    logic [1:0] [DW-1:0] z1, z2, z3;
    logic [1:0] [DW-1:0] next_z1, next_z2, next_z3, dec;
    logic mix_valid, next_mix_valid, dphase, next_dphase;
    sample_s next_out;
    logic [3:0] ph;

    // quantised cosine of a 16-step phase
    function automatic logic [DW-1:0] cos16(input logic [3:0] p);
        case (p)
            4'h0: return 12'h7ff;
            4'h1, 4'hf: return 12'h763;
            4'h2, 4'he: return 12'h5a7;
            4'h3, 4'hd: return 12'h30f;
            4'h5, 4'hb: return 12'hcf1;
            4'h6, 4'ha: return 12'ha59;
            4'h7, 4'h9: return 12'h89d;
            4'h8: return 12'h801;
            default: return 12'h000;
        endcase
    endfunction

    // accumulators keep running when not selected
    for (genvar k = 0; k < NOSC; k++) begin : g_osc
        assign next_phase[k] = phase[k] + freq[k]; // [RQ16] [RQ19]
    end

    // decimator lanes: taps 1 3 3 1, full precision, rounded once
    for (genvar l = 0; l < 2; l++) begin : g_lane
        assign dec[l] = round_sat(48'($signed(mix[l])) + 48'sh3 * 48'($signed(z1[l]))
                        + 48'sh3 * 48'($signed(z2[l])) + 48'($signed(z3[l])),
                        6'(DEC_SHIFT)); // [RQ9] [RQ13] [RQ15]
    end

    // mixing to baseband, then filter and decimate
    always_comb begin
        ph = phase[osc_sel][FW-1:FW-4];
        next_mix_valid = in_valid && active;
        next_mix = mix;
        if (in_valid && active) begin
            next_mix[0] = round_sat(48'($signed(in_data)) * 48'($signed(cos16(ph))),
                                    6'(MIX_SHIFT)); // [RQ8] [RQ17]
            next_mix[1] = round_sat(48'($signed(in_data)) * 48'($signed(cos16(ph - 4'h4))),
                                    6'(MIX_SHIFT)); // [RQ14]
        end
        next_z1 = mix_valid ? mix : z1;
        next_z2 = mix_valid ? z1 : z2;
        next_z3 = mix_valid ? z2 : z3;
        next_dphase = mix_valid ? !dphase : dphase;
        next_out = out;
        next_out.valid = mix_valid && dphase;
        if (mix_valid && dphase) begin
            next_out.i = dec[0];
            next_out.q = dec[1];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase     <= '0;
            mix       <= '0;
            mix_valid <= 1'b0;
            z1        <= '0;
            z2        <= '0;
            z3        <= '0;
            dphase    <= 1'b0;
            out       <= '0;
        end else begin
            phase     <= next_phase;
            mix       <= next_mix;
            mix_valid <= next_mix_valid;
            z1        <= next_z1;
            z2        <= next_z2;
            z3        <= next_z3;
            dphase    <= next_dphase;
            out       <= next_out;
        end
    end

    property p_osc_step;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> phase[0] == $past(phase[0]) + $past(freq[0]);
    endproperty
    a_osc_step: assert property (p_osc_step) else $error("oscillator step wrong"); // [RQ16]

    property p_decim;
        @(posedge clk) disable iff (!rst_n)
        out.valid |=> !out.valid;
    endproperty
    a_decim: assert property (p_decim) else $error("decimated output too fast"); // [RQ9]
endmodule

// ---- core/equalizer_fir_and_down_converter.sv ----
// equalizer_fir_and_down_converter: register file, equalizer modes, down converter routing
// assumes synchronous sample inputs and a plain register port with one-cycle read data
// Functional notes
// RQ1: mode 0 turns filter off; mode 2 with share/merge picks dual, single or alternating
// RQ2: dual equalization filters each channel with its own nine coefficients
// RQ3: center tap is 18 bits with lsb weight 2^-16
// RQ4: other taps are 12 bits sharing one lsb weight 2^-10 to 2^-16
// RQ5: single equalization filters the one interleaved stream with nine coefficients
// RQ6: alternating mode swaps between two coefficient sets on every sample
// RQ7: each stream goes straight out or through the down converter
// RQ8: down converter first mixes the wanted band to complex baseband
// RQ9: low-pass filtering and decimation happen as one combined step
// RQ10: in dual operation each down converter picks channel a or b
// RQ11: second converter's oscillator comes from pins or the software field
// RQ12: in single operation only one down converter works
// RQ13: precision cuts round to nearest, ties to even
// RQ14: overflowing results saturate instead of wrapping
// RQ15: decimation filters keep full precision and round only at the output
// RQ16: oscillator frequency is set by a 32-bit word
// RQ17: real sample times complex oscillator shifts input by oscillator frequency
// RQ18: select source bit 1 takes pins, 0 takes the software field
// RQ19: oscillator frequency is word times 2^-32 times clock rate
// RQ20: symmetric nine-tap structure, center tap in the middle; reprogram while off
`timescale 1ns/1ps
module equalizer_fir_and_down_converter
    import eqddc_pkg::*;
(
    input  wire logic          clk,         // device clock, 40 MHz
    input  wire logic          reset_n,     // asynchronous reset, active low
    input  wire logic [11:0]   reg_addr,    // register byte address
    input  wire logic [31:0]   reg_wdata,   // register write data
    input  wire logic          reg_wr,      // write strobe
    input  wire logic          reg_rd,      // read strobe
    output logic [31:0]        reg_rdata,   // read data, cycle after strobe
    input  wire logic          in_valid,    // converter sample strobe
    input  wire logic [DW-1:0] in_a,        // channel a or interleaved stream
    input  wire logic [DW-1:0] in_b,        // channel b
    input  wire logic [1:0]    osc_select_pins_a, // oscillator pins, converter a
    input  wire logic [1:0]    osc_select_pins_b, // oscillator pins, converter b
    output sample_s            out_a,       // output stream a
    output sample_s            out_b        // output stream b
);
    logic      rst_meta, rst_n;
    logic [31:0] ctrl, next_ctrl;
    freq_set_t freq_a, freq_b, next_freq_a, next_freq_b;
    coef_set_t set_a, set_b, next_set_a, next_set_b, fir_a_coefs;
    logic [31:0] next_rdata;
    eq_mode_e  eq_mode;
    logic      parity, next_parity;
    sample_s   next_out_a, next_out_b, ddc_a_out, ddc_b_out;
    logic      fa_valid, fb_valid;
    logic [DW-1:0] fa_data, fb_data, ddc_a_in, ddc_b_in;
    logic [1:0] osc_sel_a, osc_sel_b;
    logic [2:0] wsel;
    logic      single, bypass, fir_a_en, fir_b_en;
    logic [11:0] idx;

    // reset released through two flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // control field decode
    assign single = ctrl[CTRL_SINGLE];
    assign bypass = ctrl[CTRL_BYPASS];
    assign wsel   = (ctrl[CTRL_WSEL +: 3] > WSEL_MAX) ? WSEL_MAX : ctrl[CTRL_WSEL +: 3];
    assign idx    = reg_addr - OFS_COEF;

    // register writes
    always_comb begin
        next_ctrl   = ctrl;
        next_freq_a = freq_a;
        next_freq_b = freq_b;
        next_set_a  = set_a;
        next_set_b  = set_b;
        if (reg_wr) begin
            if (reg_addr == OFS_CTRL)
                next_ctrl = reg_wdata;
            for (int k = 0; k < NOSC; k++) begin
                if (reg_addr == OFS_FREQ + 12'(4 * k))
                    next_freq_a[k] = reg_wdata; // [RQ16]
                if (reg_addr == OFS_FREQ + 12'(4 * (k + NOSC)))
                    next_freq_b[k] = reg_wdata;
            end
            for (int k = 0; k < NTAP; k++) begin
                if (idx == 12'(4 * k))
                    next_set_a[k] = reg_wdata[17:0];
                if (idx == 12'(4 * (k + NTAP)))
                    next_set_b[k] = reg_wdata[17:0];
            end
        end
    end

    // register reads; unmapped addresses answer zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (reg_rd) begin
            if (reg_addr == OFS_CTRL)
                next_rdata = ctrl;
            if (reg_addr == OFS_STATUS)
                next_rdata = {23'h00_0000, osc_sel_b, osc_sel_a, eq_mode, parity};
            for (int k = 0; k < NOSC; k++) begin
                if (reg_addr == OFS_FREQ + 12'(4 * k))
                    next_rdata = freq_a[k];
                if (reg_addr == OFS_FREQ + 12'(4 * (k + NOSC)))
                    next_rdata = freq_b[k];
            end
            for (int k = 0; k < NTAP; k++) begin
                if (idx == 12'(4 * k))
                    next_rdata = {14'h0000, set_a[k]};
                if (idx == 12'(4 * (k + NTAP)))
                    next_rdata = {14'h0000, set_b[k]};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl      <= CTRL_RESET;
            freq_a    <= {NOSC{FREQ_RESET}};
            freq_b    <= {NOSC{FREQ_RESET}};
            set_a     <= {NTAP{COEF_RESET}};
            set_b     <= {NTAP{COEF_RESET}};
            reg_rdata <= 32'h0000_0000;
        end else begin
            ctrl      <= next_ctrl;
            freq_a    <= next_freq_a;
            freq_b    <= next_freq_b;
            set_a     <= next_set_a;
            set_b     <= next_set_b;
            reg_rdata <= next_rdata;
        end
    end

    // filter mode from mode, share, merge and converter operation
    always_comb begin
        eq_mode = EQ_OFF; // [RQ1]
        if (ctrl[CTRL_MODE +: 2] == EQ_MODE_ON) begin
            case ({ctrl[CTRL_SHARE], ctrl[CTRL_MERGE]})
                2'b00:   eq_mode = single ? EQ_OFF : EQ_DUAL;   // [RQ2]
                2'b11:   eq_mode = single ? EQ_SINGLE : EQ_OFF; // [RQ5]
                2'b01:   eq_mode = single ? EQ_TVAR : EQ_OFF;   // [RQ6]
                default: eq_mode = EQ_OFF;
            endcase
        end
    end

    // sample parity for the alternating coefficient sets
    always_comb begin
        next_parity = 1'b0;
        if (eq_mode == EQ_TVAR)
            next_parity = in_valid ? !parity : parity; // [RQ6]
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            parity <= 1'b0;
        else
            parity <= next_parity;
    end

    // coefficient set and enable per filter
    always_comb begin
        fir_a_coefs = set_a;
        if (eq_mode == EQ_TVAR && parity)
            fir_a_coefs = set_b; // [RQ6]
        fir_a_en = eq_mode != EQ_OFF;
        fir_b_en = eq_mode == EQ_DUAL; // [RQ2]
    end

    eq_fir u_fir_a (
        .clk       (clk),
        .rst_n     (rst_n),
        .enable    (fir_a_en),
        .wsel      (wsel),
        .coefs     (fir_a_coefs),
        .in_valid  (in_valid),
        .in_data   (in_a),
        .out_valid (fa_valid),
        .out_data  (fa_data)
    );

    eq_fir u_fir_b (
        .clk       (clk),
        .rst_n     (rst_n),
        .enable    (fir_b_en),
        .wsel      (wsel),
        .coefs     (set_b),
        .in_valid  (in_valid && !single),
        .in_data   (in_b),
        .out_valid (fb_valid),
        .out_data  (fb_data)
    );

    // input binding and oscillator choice per converter
    always_comb begin
        ddc_a_in  = (!single && ctrl[CTRL_BIND_A]) ? fb_data : fa_data; // [RQ10]
        ddc_b_in  = ctrl[CTRL_BIND_B] ? fb_data : fa_data;              // [RQ10]
        osc_sel_a = ctrl[CTRL_SRC] ? osc_select_pins_a : ctrl[CTRL_FSEL_A +: 2]; // [RQ18]
        osc_sel_b = ctrl[CTRL_SRC] ? osc_select_pins_b : ctrl[CTRL_FSEL_B +: 2]; // [RQ11]
    end

    ddc_path u_ddc_a (
        .clk      (clk),
        .rst_n    (rst_n),
        .freq     (freq_a),
        .osc_sel  (osc_sel_a),
        .active   (!bypass),
        .in_valid (fa_valid),
        .in_data  (ddc_a_in),
        .out      (ddc_a_out)
    );

    ddc_path u_ddc_b (
        .clk      (clk),
        .rst_n    (rst_n),
        .freq     (freq_b),
        .osc_sel  (osc_sel_b),
        .active   (!bypass && !single), // [RQ12]
        .in_valid (fa_valid),
        .in_data  (ddc_b_in),
        .out      (ddc_b_out)
    );

    // output selection: bypass or down converter
    always_comb begin
        next_out_a = ddc_a_out;
        next_out_b = ddc_b_out;
        if (bypass) begin
            next_out_a = '{valid: fa_valid, i: fa_data, q: 12'h000}; // [RQ7]
            next_out_b = '{valid: fb_valid, i: fb_data, q: 12'h000};
        end
        if (single)
            next_out_b.valid = 1'b0; // [RQ12]
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_a <= '0;
            out_b <= '0;
        end else begin
            out_a <= next_out_a;
            out_b <= next_out_b;
        end
    end

    property p_eq_off_pass;
        @(posedge clk) disable iff (!rst_n)
        (eq_mode == EQ_OFF && in_valid && bypass) |=> ##1 (out_a.i == $past(in_a, 2));
    endproperty
    a_eq_off_pass: assert property (p_eq_off_pass) else $error("disabled filter altered a"); // [RQ1]

    property p_tvar_alt;
        @(posedge clk) disable iff (!rst_n)
        (eq_mode == EQ_TVAR && in_valid) ##1 (eq_mode == EQ_TVAR) |-> parity != $past(parity);
    endproperty
    a_tvar_alt: assert property (p_tvar_alt) else $error("sets did not alternate"); // [RQ6]

    property p_bypass;
        @(posedge clk) disable iff (!rst_n)
        (bypass && in_valid) ##1 bypass |=> out_a.valid && out_a.q == 12'h000;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass output wrong"); // [RQ7]

    property p_single_b_idle;
        @(posedge clk) disable iff (!rst_n)
        single [*2] |=> !out_b.valid;
    endproperty
    a_single_b_idle: assert property (p_single_b_idle) else $error("b active in single"); // [RQ12]

    property p_pins_sel;
        @(posedge clk) disable iff (!rst_n)
        ctrl[CTRL_SRC] |-> osc_sel_b == osc_select_pins_b && osc_sel_a == osc_select_pins_a;
    endproperty
    a_pins_sel: assert property (p_pins_sel) else $error("pins not selecting"); // [RQ18]

    property p_field_sel;
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == OFS_CTRL && !reg_wdata[CTRL_SRC])
            |=> osc_sel_b == $past(reg_wdata[CTRL_FSEL_B +: 2]);
    endproperty
    a_field_sel: assert property (p_field_sel) else $error("field not selecting"); // [RQ11]

    c_dual:   cover property (@(posedge clk) disable iff (!rst_n) eq_mode == EQ_DUAL && in_valid);
    c_tvar:   cover property (@(posedge clk) disable iff (!rst_n) eq_mode == EQ_TVAR && parity);
    c_ddc_out: cover property (@(posedge clk) disable iff (!rst_n) !bypass && out_a.valid);
endmodule

// ---- dv/adc_source.sv ----
// adc_source: upstream converter model, emits bursts of constant samples
// assumes the bench pulses go for one cycle and holds va and vb during a burst
`timescale 1ns/1ps
module adc_source
    import eqddc_pkg::*;
(
    input  wire logic          clk,      // device clock
    input  wire logic          go,       // burst start
    input  wire logic [7:0]    n,        // burst length
    input  wire logic [DW-1:0] va,       // channel a value
    input  wire logic [DW-1:0] vb,       // channel b value
    output logic               in_valid, // sample strobe
    output logic [DW-1:0]      in_a,     // channel a
    output logic [DW-1:0]      in_b      // channel b
);
    logic [7:0] left = 8'h00;
    // burst counter, one sample per cycle
    always_ff @(posedge clk) begin
        left <= go ? n : ((left != 8'h00) ? left - 8'h01 : left);
    end
    // outside a burst the lines show the inverse so stale data never matches
    assign in_valid = (left != 8'h00);
    assign in_a     = in_valid ? va : ~va;
    assign in_b     = in_valid ? vb : ~vb;
endmodule

// ---- dv/testbench.sv ----
// testbench: register port, equalizer modes, bypass and down converter checks
// assumes the adc_source model feeds the samples and a 40 MHz device clock
`timescale 1ns/1ps
module testbench;
    import eqddc_pkg::*;
    logic          clk       = 1'b0;
    logic          reset_n   = 1'b0;
    logic [11:0]   reg_addr  = 12'h000;
    logic [31:0]   reg_wdata = 32'h0000_0000;
    logic          reg_wr    = 1'b0;
    logic          reg_rd    = 1'b0;
    logic          go        = 1'b0;
    logic [1:0]    pins_b    = 2'h0;
    logic [DW-1:0] va        = 12'h000;
    logic [DW-1:0] vb        = 12'h000;
    logic [31:0]   reg_rdata;
    logic [31:0]   rd;
    logic          in_valid;
    logic [DW-1:0] in_a;
    logic [DW-1:0] in_b;
    sample_s       out_a;
    sample_s       out_b;
    sample_s       last_a;
    sample_s       last_b;
    sample_s       prev_a;
    int            n_fail    = 0;
    int            tests_run = 0;
    int            na        = 0;
    int            nb        = 0;

    // device clock, 25 ns
    initial forever #12.5 clk = ~clk;

    adc_source src (.clk(clk), .go(go), .n(8'h10), .va(va), .vb(vb),
                    .in_valid(in_valid), .in_a(in_a), .in_b(in_b));
    equalizer_fir_and_down_converter dut (.clk(clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .in_valid(in_valid), .in_a(in_a), .in_b(in_b),
        .osc_select_pins_a(2'h1), .osc_select_pins_b(pins_b), .out_a(out_a), .out_b(out_b));

    // output monitor keeps the last two a samples and the last b sample and counts them
    always @(posedge clk) begin
        if (out_a.valid === 1'b1) begin
            prev_a <= last_a;
            last_a <= out_a;
            na     <= na + 1;
        end
        if (out_b.valid === 1'b1) begin
            last_b <= out_b;
            nb     <= nb + 1;
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rdr(input logic [11:0] a);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 rd = reg_rdata;
    endtask
    task automatic stat(input eq_mode_e m);
        rdr(OFS_STATUS);
        chk("eq mode", 32'(rd[4:1]), 32'(m));
    endtask
    task automatic burst(input logic [DW-1:0] a, input logic [DW-1:0] b);
        @(posedge clk);
        va <= a;
        vb <= b;
        go <= 1'b1;
        na = 0;
        nb = 0;
        @(posedge clk);
        go <= 1'b0;
        repeat (24) @(posedge clk);
        #1;
    endtask

    task automatic t_reset_bypass;
        rdr(OFS_CTRL);
        chk("ctrl", rd, CTRL_RESET);
        rdr(OFS_FREQ + 12'h01C);
        chk("freq b3", rd, FREQ_RESET);
        rdr(OFS_COEF + 12'h044);
        chk("coef b8", rd, 32'(COEF_RESET));
        rdr(12'hFFC);
        chk("unmapped", rd, 32'h0000_0000);
        stat(EQ_OFF);
        burst(12'h123, 12'h456);
        chk("byp a", 32'(last_a.i), 32'h0000_0123);
        chk("byp q", 32'(last_a.q), 32'h0000_0000);
        chk("byp b", 32'(last_b.i), 32'h0000_0456);
        chk("byp n", 32'(na), 32'h0000_0010);
        $display("test reset and bypass done");
    endtask
    task automatic t_dual;
        wr(OFS_COEF, 32'h0000_0400);
        wr(OFS_COEF + 12'h034, 32'h0000_8000);
        wr(OFS_CTRL, 32'h0000_0502);
        stat(EQ_DUAL);
        burst(12'h100, 12'h200);
        chk("dual a", 32'(last_a.i), 32'h0000_0100);
        chk("dual b", 32'(last_b.i), 32'h0000_0100);
        wr(OFS_CTRL, 32'h0000_0562);
        burst(12'h400, 12'h200);
        chk("wsel6 a", 32'(last_a.i), 32'h0000_0010);
        chk("wsel6 b", 32'(last_b.i), 32'h0000_0100);
        $display("test dual equalization done");
    endtask
    task automatic t_tvar_single;
        wr(OFS_CTRL, 32'h0000_050A);
        stat(EQ_OFF);
        wr(OFS_CTRL, 32'h0000_058A);
        stat(EQ_TVAR);
        burst(12'h200, 12'h000);
        chk("tvar odd", 32'(last_a.i), 32'h0000_0100);
        chk("tvar even", 32'(prev_a.i), 32'h0000_0200);
        wr(OFS_CTRL, 32'h0000_058E);
        stat(EQ_SINGLE);
        burst(12'h100, 12'h300);
        chk("single a", 32'(last_a.i), 32'h0000_0100);
        chk("single b n", 32'(nb), 32'h0000_0000);
        $display("test alternating and single done");
    endtask
    task automatic t_ddc_osc;
        wr(OFS_CTRL, 32'h0000_0400);
        burst(12'h100, 12'h200);
        chk("ddc n", 32'(na), 32'h0000_0008);
        chk("ddc i", 32'(last_a.i), 32'h0000_0100);
        chk("ddc b i", 32'(last_b.i), 32'h0000_0200);
        chk("ddc q", 32'(last_a.q), 32'h0000_0000);
        wr(OFS_FREQ + 12'h010, 32'h1234_5678);
        rdr(OFS_FREQ + 12'h010);
        chk("freq b0", rd, 32'h1234_5678);
        wr(OFS_CTRL, 32'h0000_8400);
        rdr(OFS_STATUS);
        chk("osc field", 32'(rd[8:7]), 32'h0000_0002);
        @(posedge clk);
        pins_b <= 2'h3;
        wr(OFS_CTRL, 32'h0000_8C00);
        rdr(OFS_STATUS);
        chk("osc pins", 32'(rd[8:7]), 32'h0000_0003);
        chk("osc pins a", 32'(rd[6:5]), 32'h0000_0001);
        $display("test down converter done");
    endtask

    task automatic close_out;
        $display("counts: run %0d mismatched %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset_bypass();
        t_dual();
        t_tvar_single();
        t_ddc_osc();
        close_out();
    end
    // watchdog, far beyond the roughly 220 cycles the tests need
    initial begin
        #(25 * 5000);
        n_fail++;
        close_out();
    end
endmodule
